/* File: common/irq_path_consts.svh */
// timing and field constants for the interrupt path
`ifndef IRQ_PATH_CONSTS_SVH
`define IRQ_PATH_CONSTS_SVH
`define NUM_CHAN        4
`define NUM_WAKE        16
`define NUM_EXT_WAKE    4
`define PRIO_W          3
`define PRIO_LOWEST     3'h7
`define VEC_W           7
`define ARB_PERIOD      3'h5
`define ACK_EXTRA       3'h1
`define IMC_BASE        5'h12
`define IMC_STACK_RF    5'h02
`define IMC_CS_PUSH     5'h02
`define WFI_DELAY       5'h01
`define STOP_KEY1       8'h5a
`define STOP_KEY2       8'ha5
`endif

/* File: common/irq_path_pkg.sv */
// types shared by the interrupt path files
package irq_path_pkg;
    typedef enum logic [1:0] {
        ARB_IDLE = 2'b00,
        ARB_SAMP = 2'b01,
        ARB_ACK  = 2'b11,
        ARB_IMC  = 2'b10
    } arb_state_e;
    typedef logic [2:0] prio_t;
    typedef logic [6:0] vec_t;
endpackage

/* File: verilog/sync_bit.sv */
// two flip-flop level synchroniser
`timescale 1ns/1ps
module sync_bit (
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // level in and out
    input  wire logic d,
    output logic      q
);
    logic meta_r;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_r <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

/* File: verilog/nmi_wakeup_interrupt_path.sv */
// emergency line, wake-up unit, channel arbitration and response timing
`timescale 1ns/1ps
`include "irq_path_consts.svh"
// Summary of operation
// - channel pending set by event; software sets, clears and reads it
// - channel requests only with mask, pending and global enable all 1
// - three-bit priority, 0 highest; level 7 never acknowledged
// - each channel has a seven-bit vector selecting the table entry
// - one emergency/wake-zero pin feeds motor controller and wake unit
// - emergency acknowledged by cpu only when not stopped
// - motor controller catches emergency line asynchronously, any mode
// - wake unit catches enabled edges on four lines asynchronously
// - emergency: phases high impedance, emergency flag set, request cpu
// - top pending cleared on acknowledge; software clears emergency flag
// - stop entered only by key sequence; any enabled one of the four external wake lines leaves it
// - wake-zero in stop wakes device and emergency then serviced
// - sixteen wake lines, four external; unused ones software usable
// - arbitration every 5 cycles; one extra cycle on acknowledge
// - abort instruction if no write yet, else let it finish
// - external channel latency 22 to 51 cycles by instruction
// - top-level latency 22 to 51 cycles by instruction
// - machine cycle 18, plus 2 stack in file, plus 2 segment push
// - one extra cycle when leaving wait-for-interrupt
// - top pending set by event or software, cleared on acknowledge
module nmi_wakeup_interrupt_path
    import irq_path_pkg::*;
(
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     nrst,
    // peripheral channels
    input  wire logic [`NUM_CHAN-1:0]     chan_trigger,
    input  wire logic [`NUM_CHAN-1:0]     chan_pend_set,
    input  wire logic [`NUM_CHAN-1:0]     chan_pend_clr,
    input  wire logic [`NUM_CHAN-1:0]     channel_mask_enable,
    input  wire irq_path_pkg::prio_t      channel_priority_level [`NUM_CHAN],
    input  wire irq_path_pkg::vec_t       channel_vector_select [`NUM_CHAN],
    // central control
    input  wire logic                     global_irq_enable,
    input  wire logic                     top_level_enable,
    input  wire logic                     top_level_unm_set,
    input  wire logic                     top_pend_sw_set,
    // motor controller emergency
    input  wire logic                     wake_line_zero,
    input  wire logic                     emergency_level_select,
    input  wire logic                     emergency_irq_enable,
    input  wire logic                     emergency_flag_clr,
    // wake-up unit
    input  wire logic [`NUM_EXT_WAKE-2:0] wake_lines_upper,
    input  wire logic [`NUM_WAKE-1:0]     wake_mask_low,
    input  wire logic [`NUM_WAKE-1:0]     wake_trigger_low,
    input  wire logic [`NUM_WAKE-1:0]     wake_pend_set,
    input  wire logic [`NUM_WAKE-1:0]     wake_pend_clr,
    input  wire logic                     stop_key_wr,
    input  wire logic [7:0]               stop_key_data,
    // cpu side
    input  wire logic                     wait_mode,
    input  wire logic                     write_done,
    input  wire logic                     instr_end,
    input  wire logic                     stack_in_file,
    input  wire logic                     code_segment_push_enable,
    // status and requests
    output logic [`NUM_CHAN-1:0]          channel_pending_flag,
    output logic [`NUM_WAKE-1:0]          wake_pending,
    output logic                          wake_irq,
    output logic                          top_level_pending,
    output logic                          top_level_unmaskable,
    output logic                          emergency_flag,
    output logic                          phase_hiz,
    output logic                          stop_mode,
    output logic                          ack_pulse,
    output logic                          ack_top,
    output irq_path_pkg::vec_t            ack_vector,
    output logic                          abort_instr,
    output logic                          service_start
);
    // ********************************
    // shared pin and synchronisers
    // ********************************
    // one pin for both consumers
    logic [`NUM_EXT_WAKE-1:0] ext_lines;
    logic [`NUM_EXT_WAKE-1:0] ext_sync;
    logic [`NUM_EXT_WAKE-1:0] ext_prev_r;
    assign ext_lines = {wake_lines_upper, wake_line_zero};

    genvar g;
    generate
        for (g = 0; g < `NUM_EXT_WAKE; g++) begin : gen_sync
            sync_bit u_sync (
                .clk  (clk),
                .nrst (nrst),
                .d    (ext_lines[g]),
                .q    (ext_sync[g])
            );
        end
    endgenerate

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) ext_prev_r <= '0;
        else       ext_prev_r <= ext_sync;
    end

    // ********************************
    // motor controller emergency
    // ********************************
    // the shutdown path acts on the raw pin so phases float even in stop;
    // the flag is set from the synchronised edge for the cpu side.
    logic emg_active;
    logic emg_edge;
    logic emergency_flag_nxt;
    assign emg_active = emergency_irq_enable
                        & (wake_line_zero == emergency_level_select);
    assign emg_edge   = emergency_irq_enable
                        & (ext_sync[0] == emergency_level_select)
                        & (ext_prev_r[0] != emergency_level_select);
    assign emergency_flag_nxt = emg_edge | (emergency_flag
                                & ~emergency_flag_clr);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            emergency_flag <= 1'b0;
            phase_hiz      <= 1'b0;
        end else begin
            emergency_flag <= emergency_flag_nxt;
            phase_hiz      <= emg_active | emergency_flag_nxt;
        end
    end

    // ********************************
    // wake-up unit
    // ********************************
    logic [`NUM_WAKE-1:0] wake_edge;
    logic [`NUM_WAKE-1:0] wake_pending_nxt;
    logic [`NUM_EXT_WAKE-1:0] ext_rise;
    logic [`NUM_EXT_WAKE-1:0] ext_fall;
    logic [`NUM_EXT_WAKE-1:0] ext_hit;
    logic                     wake_any;
    assign ext_rise = ext_sync & ~ext_prev_r;
    assign ext_fall = ~ext_sync & ext_prev_r;
    assign ext_hit  = (ext_rise & wake_trigger_low[`NUM_EXT_WAKE-1:0])
                      | (ext_fall & ~wake_trigger_low[`NUM_EXT_WAKE-1:0]);
    assign wake_edge = {{(`NUM_WAKE-`NUM_EXT_WAKE){1'b0}}, ext_hit};
    assign wake_pending_nxt = wake_edge | wake_pend_set
                              | (wake_pending & ~wake_pend_clr);
    // raw pins wake from stop since the synchronised copy may not move
    // when the system clock is gated in a real chip
    assign wake_any = |((ext_lines ^ ~wake_trigger_low[`NUM_EXT_WAKE-1:0])
                        & wake_mask_low[`NUM_EXT_WAKE-1:0]);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wake_pending <= '0;
            wake_irq     <= 1'b0;
        end else begin
            wake_pending <= wake_pending_nxt;
            wake_irq     <= |(wake_pending_nxt & wake_mask_low);
        end
    end

    // ********************************
    // stop mode
    // ********************************
    logic key_armed_r;
    logic stop_mode_nxt;
    logic key_first;
    logic key_second;
    assign key_first  = stop_key_wr & (stop_key_data == `STOP_KEY1);
    assign key_second = stop_key_wr & (stop_key_data == `STOP_KEY2)
                        & key_armed_r;
    assign stop_mode_nxt = stop_mode ? ~(wake_any | |(wake_edge
                           & wake_mask_low)) : key_second;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            key_armed_r <= 1'b0;
            stop_mode   <= 1'b0;
        end else begin
            key_armed_r <= key_first;
            stop_mode   <= stop_mode_nxt;
        end
    end

    // ********************************
    // channel pending and top level
    // ********************************
    logic [`NUM_CHAN-1:0] chan_pend_nxt;
    logic [`NUM_CHAN-1:0] chan_ack;
    logic                 top_pend_nxt;
    logic                 top_ack;
    assign chan_pend_nxt = chan_trigger | chan_pend_set
                           | (channel_pending_flag & ~chan_pend_clr
                              & ~chan_ack);
    assign top_pend_nxt = emg_edge | top_pend_sw_set
                          | (top_level_pending & ~top_ack);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            channel_pending_flag <= '0;
            top_level_pending    <= 1'b0;
            top_level_unmaskable <= 1'b0;
        end else begin
            channel_pending_flag <= chan_pend_nxt;
            top_level_pending    <= top_pend_nxt;
            top_level_unmaskable <= top_level_unmaskable | top_level_unm_set;
        end
    end

    // ********************************
    // arbitration
    // ********************************
    logic [`NUM_CHAN-1:0] chan_req;
    logic                 top_req;
    logic                 any_req;
    prio_t                best_prio;
    logic [1:0]           best_idx;
    assign chan_req = channel_mask_enable & channel_pending_flag
                      & {`NUM_CHAN{global_irq_enable}};
    assign top_req = top_level_pending & ~stop_mode
                     & (top_level_unmaskable
                        | (top_level_enable & global_irq_enable));

    // lowest value wins, level 7 excluded
    always_comb begin
        best_prio = `PRIO_LOWEST;
        best_idx  = 2'h0;
        for (int i = `NUM_CHAN - 1; i >= 0; i--) begin
            if (chan_req[i] && channel_priority_level[i] <= best_prio
                && channel_priority_level[i] != `PRIO_LOWEST) begin
                best_prio = channel_priority_level[i];
                best_idx  = 2'(i);
            end
        end
    end
    assign any_req = top_req | (best_prio != `PRIO_LOWEST & ~stop_mode);

    arb_state_e state_r;
    arb_state_e state_nxt;
    logic [2:0] arb_cnt_r;
    logic [4:0] imc_cnt_r;
    logic [4:0] imc_len;
    logic       sample_pt;
    logic       win_top_r;
    logic [1:0] win_idx_r;
    logic       can_go;
    assign sample_pt = (arb_cnt_r == `ARB_PERIOD - 3'h1);
    assign can_go = ~write_done | instr_end;
    assign imc_len = `IMC_BASE
                     + (stack_in_file ? `IMC_STACK_RF : 5'h00)
                     + (code_segment_push_enable ? `IMC_CS_PUSH : 5'h00)
                     + (wait_mode ? `WFI_DELAY : 5'h00);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ARB_IDLE: if (sample_pt && any_req) state_nxt = ARB_SAMP;
            ARB_SAMP: if (can_go) state_nxt = ARB_ACK;
            ARB_ACK:  state_nxt = ARB_IMC;
            ARB_IMC:  if (imc_cnt_r == 5'h01) state_nxt = ARB_IDLE;
        endcase
    end

    assign chan_ack = (state_r == ARB_ACK && !win_top_r)
                      ? 4'(1 << win_idx_r) : '0;
    assign top_ack  = (state_r == ARB_ACK) & win_top_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            arb_cnt_r <= 3'h0;
            state_r   <= ARB_IDLE;
        end else begin
            arb_cnt_r <= sample_pt ? 3'h0 : arb_cnt_r + 3'h1;
            state_r   <= state_nxt;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            win_top_r <= 1'b0;
            win_idx_r <= 2'h0;
            imc_cnt_r <= 5'h00;
        end else begin
            if (state_r == ARB_IDLE && sample_pt && any_req) begin
                win_top_r <= top_req;
                win_idx_r <= best_idx;
            end
            if (state_r == ARB_ACK) imc_cnt_r <= imc_len;
            else if (imc_cnt_r != 5'h00) imc_cnt_r <= imc_cnt_r - 5'h01;
        end
    end

    // ********************************
    // cpu outputs
    // ********************************
    // vector of the acknowledged channel
    // channel latency falls out of pending flop, sample and machine cycle; channel events pass no synchroniser
    // top level skips no stage but is decided first
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ack_pulse     <= 1'b0;
            ack_top       <= 1'b0;
            ack_vector    <= '0;
            abort_instr   <= 1'b0;
            service_start <= 1'b0;
        end else begin
            ack_pulse     <= (state_r == ARB_ACK);
            ack_top       <= top_ack;
            if (state_r == ARB_ACK && !win_top_r)
                ack_vector <= channel_vector_select[win_idx_r];
            abort_instr   <= (state_r == ARB_SAMP) & ~write_done;
            service_start <= (state_r == ARB_IMC) & (imc_cnt_r == 5'h01);
        end
    end
endmodule

/* File: verification/irq_path_assertions.sv */
// assertion checker for the interrupt path ports
`timescale 1ns/1ps
`include "irq_path_consts.svh"
module irq_path_checker
    import irq_path_pkg::*;
(
    // clock and reset
    input wire logic                 clk,
    input wire logic                 nrst,
    // inputs watched
    input wire logic [`NUM_CHAN-1:0] chan_trigger,
    input wire logic [`NUM_CHAN-1:0] chan_pend_set,
    input wire logic [`NUM_CHAN-1:0] chan_pend_clr,
    input wire logic                 top_level_unm_set,
    input wire logic                 stop_key_wr,
    input wire logic [7:0]           stop_key_data,
    input wire logic                 wait_mode,
    input wire logic                 stack_in_file,
    input wire logic                 code_segment_push_enable,
    // outputs watched
    input wire logic [`NUM_CHAN-1:0] channel_pending_flag,
    input wire logic                 top_level_unmaskable,
    input wire logic                 emergency_flag,
    input wire logic                 phase_hiz,
    input wire logic                 stop_mode,
    input wire logic                 ack_pulse,
    input wire logic                 ack_top,
    input wire logic                 abort_instr,
    input wire logic                 service_start
);
    // ****************************************
    // machine cycle tracking
    // ****************************************
    logic [4:0]           cnt_r;
    logic [4:0]           len_r;
    logic [`NUM_CHAN-1:0] clr_only;
    assign clr_only = chan_pend_clr & ~chan_pend_set & ~chan_trigger;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // extras latched at acknowledge; levels may move after the routine
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= 5'h00;
            len_r <= 5'h00;
        end else if (ack_pulse) begin
            cnt_r <= 5'h01;
            len_r <= `IMC_BASE + (stack_in_file ? `IMC_STACK_RF : 5'h00)
                + (code_segment_push_enable ? `IMC_CS_PUSH : 5'h00)
                + (wait_mode ? `WFI_DELAY : 5'h00);
        end else if (cnt_r != 5'h1f) begin
            cnt_r <= cnt_r + 5'h01;
        end
    end
    a_chan_set: assert property (
        chan_pend_set != 0 |=> (channel_pending_flag
        & $past(chan_pend_set)) == $past(chan_pend_set))
        else $error("channel pending not set by software");
    a_chan_clr: assert property (
        clr_only != 0 |=> (channel_pending_flag & $past(clr_only)) == 0)
        else $error("channel pending not cleared by software");
    a_unm_set: assert property (
        top_level_unm_set |=> top_level_unmaskable)
        else $error("unmaskable bit not set");
    a_unm_hold: assert property (
        top_level_unmaskable |=> top_level_unmaskable)
        else $error("unmaskable bit dropped without reset");
    a_hiz_flag: assert property (
        emergency_flag |-> phase_hiz)
        else $error("phases driven while emergency flagged");
    a_top_pair: assert property (
        ack_top |-> ack_pulse)
        else $error("top acknowledge without acknowledge pulse");
    a_stop_none: assert property (
        stop_mode |-> !ack_pulse)
        else $error("acknowledge while stopped");
    a_ack_gap: assert property (
        ack_pulse |=> !ack_pulse [*8])
        else $error("acknowledges too close");
    a_svc_len: assert property (
        service_start |-> cnt_r == len_r)
        else $error("machine cycle length wrong");
    a_svc_due: assert property (
        ack_pulse |-> ##[18:23] service_start)
        else $error("routine start missing after acknowledge");
    a_abort_ack: assert property (
        abort_instr |=> ack_pulse)
        else $error("abort without acknowledge");
    a_stop_key: assert property (
        $rose(stop_mode) |-> $past(stop_key_wr && stop_key_data == `STOP_KEY2)
        && $past(stop_key_wr && stop_key_data == `STOP_KEY1, 2))
        else $error("stop entered without key sequence");
    cover property (ack_top);
    cover property (service_start);
    cover property ($rose(stop_mode));
endmodule
bind nmi_wakeup_interrupt_path irq_path_checker u_chk (.clk, .nrst,
    .chan_trigger, .chan_pend_set, .chan_pend_clr, .top_level_unm_set,
    .stop_key_wr, .stop_key_data, .wait_mode, .stack_in_file,
    .code_segment_push_enable, .channel_pending_flag, .top_level_unmaskable,
    .emergency_flag, .phase_hiz, .stop_mode, .ack_pulse, .ack_top,
    .abort_instr, .service_start);

/* File: verification/cpu_core_model.sv */
// behavioural cpu core driving instruction flow and the emergency routine
`timescale 1ns/1ps
module cpu_core_model (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // from the interrupt path
    input wire logic ack_pulse,
    input wire logic service_start,
    input wire logic emergency_flag,
    input wire logic wake_line_zero,
    // to the interrupt path
    output logic     write_done,
    output logic     instr_end,
    output logic     wait_mode,
    output logic     stack_in_file,
    output logic     code_segment_push_enable,
    output logic     emergency_flag_clr
);
    // ****************************************
    // core behaviour
    // ****************************************
    logic rout_r;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {write_done, instr_end, wait_mode} <= 3'h0;
            {stack_in_file, code_segment_push_enable} <= 2'h0;
            {emergency_flag_clr, rout_r} <= 2'h0;
        end else begin
            // writes and instruction ends vary every cycle
            write_done <= #1 1'($urandom_range(1));
            instr_end <= #1 ($urandom_range(3) == 0);
            // stack and segment options only change at routine start
            if (service_start) begin
                {wait_mode, stack_in_file, code_segment_push_enable}
                    <= #1 3'($urandom);
            end
            rout_r <= service_start | (rout_r & ~emergency_flag_clr);
            // clear the flag in the routine once line is low
            emergency_flag_clr <= #1 rout_r & emergency_flag & ~wake_line_zero
                & ~emergency_flag_clr;
        end
    end
endmodule

/* File: verification/testbench.sv */
// self-checking bench for the interrupt path
`timescale 1ns/1ps
`include "irq_path_consts.svh"
module testbench;
    import irq_path_pkg::*;
    // ****************************************
    // stimulus and observation
    // ****************************************
    logic        clk = 0, nrst = 0, gen = 0, tle = 0, unm = 0, nen = 0;
    logic        wk0 = 0, skw = 0, tsw = 0, wd, ie, wm, sif, csp, eclr;
    logic [3:0]  trg = '0, pset = '0, pclr = '0, msk = '0, cpf;
    logic [2:0]  wku = '0;
    logic [15:0] wml = '0, wtl = '0, wps = '0, wpc = '0, wpend;
    logic [7:0]  skd = '0;
    prio_t       prio [4] = '{default: 3'h7};
    vec_t        vec [4] = '{default: 7'h00};
    logic        wirq, tlp, tlu, eflag, hiz, stp, ack, ackt, abrt, svc;
    vec_t        avec;
    int          error_cnt = 0, num_checks = 0, cyc = 0;
    always #10 clk = ~clk;
    nmi_wakeup_interrupt_path uut (.clk, .nrst, .chan_trigger(trg),
        .chan_pend_set(pset), .chan_pend_clr(pclr), .channel_mask_enable(msk),
        .channel_priority_level(prio), .channel_vector_select(vec),
        .global_irq_enable(gen), .top_level_enable(tle),
        .top_level_unm_set(unm), .top_pend_sw_set(tsw),
        .wake_line_zero(wk0), .emergency_level_select(1'b1),
        .emergency_irq_enable(nen), .emergency_flag_clr(eclr),
        .wake_lines_upper(wku), .wake_mask_low(wml), .wake_trigger_low(wtl),
        .wake_pend_set(wps), .wake_pend_clr(wpc), .stop_key_wr(skw),
        .stop_key_data(skd), .wait_mode(wm), .write_done(wd),
        .instr_end(ie), .stack_in_file(sif), .code_segment_push_enable(csp),
        .channel_pending_flag(cpf), .wake_pending(wpend), .wake_irq(wirq),
        .top_level_pending(tlp), .top_level_unmaskable(tlu),
        .emergency_flag(eflag), .phase_hiz(hiz), .stop_mode(stp),
        .ack_pulse(ack), .ack_top(ackt), .ack_vector(avec),
        .abort_instr(abrt), .service_start(svc));
    cpu_core_model u_cpu (.clk, .nrst, .ack_pulse(ack), .service_start(svc),
        .emergency_flag(eflag), .wake_line_zero(wk0), .write_done(wd),
        .instr_end(ie), .wait_mode(wm), .stack_in_file(sif),
        .code_segment_push_enable(csp), .emergency_flag_clr(eclr));
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic chk_bit(input string n, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic chk_val(input string n, input logic [15:0] e,
                           input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic logic sig(input int k);
        case (k)
            0: return ack;
            1: return svc;
            2: return !stp;
            default: return !eflag;
        endcase
    endfunction
    task automatic seek(input int k, input int n, output logic h,
                        output int t);
        for (t = 0; t < n && !sig(k); t++) tick();
        h = sig(k);
    endtask
    function automatic logic [15:0] mc_len(input logic s, c, w);
        return 16'(`IMC_BASE) + (s ? 16'(`IMC_STACK_RF) : 16'h0000)
            + (c ? 16'(`IMC_CS_PUSH) : 16'h0000)
            + (w ? 16'(`WFI_DELAY) : 16'h0000);
    endfunction
    task automatic lat_check();
        logic [15:0] e;
        int          t;
        logic        h;
        e = mc_len(sif, csp, wm);
        seek(1, 40, h, t);
        chk_val("routine start", e, 16'(t));
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic chan_test();
        int   c, t;
        logic h;
        c = $urandom_range(3);
        prio[c] = prio_t'($urandom_range(6));
        vec[c] = vec_t'($urandom);
        gen = 1;
        trg[c] = 1;
        tick();
        trg = '0;
        seek(0, 40, h, t);
        chk_bit("masked ack", 1'b0, h);
        chk_bit("pending", 1'b1, cpf[c]);
        pclr[c] = 1;
        tick();
        pclr = '0;
        tick();
        chk_bit("pending cleared", 1'b0, cpf[c]);
        msk[c] = 1;
        pset[c] = 1;
        tick();
        pset = '0;
        seek(0, 40, h, t);
        chk_bit("ack", 1'b1, h);
        chk_val("vector", 16'(vec[c]), 16'(avec));
        lat_check();
        chk_bit("pending after ack", 1'b0, cpf[c]);
        prio[c] = `PRIO_LOWEST;
        pset[c] = 1;
        tick();
        pset = '0;
        seek(0, 40, h, t);
        chk_bit("lowest level ack", 1'b0, h);
        pclr[c] = 1;
        tick();
        {pclr, msk} = '0;
        $display("test channel %0d done", c);
    endtask
    task automatic enter_stop();
        wpc = '1;
        skw = 1;
        skd = `STOP_KEY2;
        tick();
        {wpc, skd} = {16'h0000, `STOP_KEY1};
        tick();
        skw = 0;
        tick();
        chk_bit("stop wrong order", 1'b0, stp);
        skw = 1;
        tick();
        skd = `STOP_KEY2;
        tick();
        skw = 0;
        tick();
        chk_bit("stop entered", 1'b1, stp);
    endtask
    task automatic emerg_test(input logic in_stop);
        int   t;
        logic h;
        {unm, tle, nen, wml[0], wtl[0]} = 5'h1f;
        if (in_stop) enter_stop();
        wk0 = 1;
        repeat (4) tick();
        chk_bit("emergency flag", 1'b1, eflag);
        chk_bit("phases released", 1'b1, hiz);
        seek(2, 10, h, t);
        chk_bit("woken", 1'b1, h);
        seek(0, 60, h, t);
        chk_bit("top ack", 1'b1, h & ackt);
        lat_check();
        chk_bit("top pending", 1'b0, tlp);
        tick();
        wk0 = 0;
        seek(3, 30, h, t);
        chk_bit("flag cleared", 1'b1, h);
        tick();
        chk_bit("phases back", 1'b0, hiz);
        tsw = 1;
        tick();
        tsw = 0;
        seek(0, 40, h, t);
        chk_bit("soft top ack", 1'b1, h & ackt);
        lat_check();
        $display("test emergency stop=%b done", in_stop);
    endtask
    task automatic wake_test();
        int   l, t;
        logic h;
        l = $urandom_range(3, 1);
        {wml[l], wtl[l]} = 2'h3;
        enter_stop();
        wku[l-1] = 1;
        seek(2, 10, h, t);
        chk_bit("upper line wake", 1'b1, h);
        repeat (2) tick();
        chk_bit("wake pending", 1'b1, wpend[l]);
        l = $urandom_range(15, 4);
        tick();
        {wku, wml, wpc} = {3'h0, 16'h0000, 16'hffff};
        tick();
        {wpc, wps[l]} = {16'h0000, 1'b1};
        tick();
        wps = '0;
        tick();
        chk_bit("masked soft line", 1'b0, wirq);
        wml[l] = 1;
        tick();
        tick();
        chk_bit("soft line irq", 1'b1, wirq);
        $display("test wake lines done");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // hang guard well above the at most about 1000 cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            final_report();
        end
    end
    initial begin
        void'($urandom(85201));
        repeat (5) @(posedge clk);
        #1 nrst = 1;
        tick();
        chk_bit("top pending at reset", 1'b0, tlp);
        repeat (3) chan_test();
        emerg_test(1'b0);
        emerg_test(1'b1);
        wake_test();
        final_report();
    end
endmodule
